// ===== shared/tcw_regs.svh
// Register offsets, field positions, reset values and divider taps of the window timer
`ifndef TCW_REGS_SVH
`define TCW_REGS_SVH

`define TCW_ADDR_W        12
`define TCW_CTRL_OFS      12'h000
`define TCW_CMP_LO_OFS    12'h004
`define TCW_CMP_HI_OFS    12'h008
`define TCW_COUNT_OFS     12'h00C

`define TCW_RUN_BIT       5
`define TCW_SRC_MSB       4
`define TCW_SRC_LSB       2
`define TCW_MODE_BIT      0

`define TCW_CTRL_RST      8'h00
`define TCW_CMP_RST       16'hFFFF
`define TCW_COUNT_RST     16'h0000

`define TCW_SRC_TAP0      3'h0
`define TCW_SRC_TAP1      3'h1
`define TCW_SRC_TAP2      3'h2
`define TCW_SRC_TAP3      3'h3
`define TCW_SRC_FAST      3'h4
`define TCW_SRC_SLOWCLK   3'h5
`define TCW_SRC_RSVD      3'h6
`define TCW_SRC_PIN       3'h7

`define TCW_HF_DIV_W      23
`define TCW_LF_DIV_W      15
`define TCW_HF_TAP_A      23
`define TCW_HF_TAP_B      13
`define TCW_HF_TAP_C      8
`define TCW_HF_TAP_D      3
`define TCW_LF_TAP_A      15
`define TCW_LF_TAP_B      5
`define TCW_UPPER_LSB     11

`endif

// ===== shared/tcw_pkg.sv
// Types shared by the window timer modules
package tcw_pkg;

  typedef enum logic [3:0] {
    TCW_PM_NORMAL1,
    TCW_PM_NORMAL_MODE_TWO,
    TCW_PM_IDLE1,
    TCW_PM_IDLE2,
    TCW_PM_LOW_SPEED_MODE_ONE,
    TCW_PM_LOW_SPEED_MODE_TWO,
    TCW_PM_SLEEP1,
    TCW_PM_SLEEP2,
    TCW_PM_STOP
  } tcw_power_mode_t;

  typedef enum logic [1:0] {
    TCW_OP_TIMER,
    TCW_OP_EVENT,
    TCW_OP_WINDOW
  } tcw_op_t;

  typedef struct packed {
    logic       run_control;
    logic [2:0] source_clock_select;
    logic       mode_select;
  } tcw_ctrl_t;

  typedef struct packed {
    logic hf;
    logic hf_a;
    logic hf_b;
    logic hf_c;
    logic hf_d;
    logic lf;
    logic lf_a;
    logic lf_b;
  } tcw_taps_t;

  typedef struct packed {
    logic hit_ctrl;
    logic hit_cmp_lo;
    logic hit_cmp_hi;
    logic hit_count;
    logic setup;
    logic wr;
  } tcw_bus_req_t;

endpackage

// ===== rtl/tcw_apb_decode.sv
// APB address decode and phase tracking for the window timer registers
`include "tcw_regs.svh"

module tcw_apb_decode
  import tcw_pkg::*;
(
  input  wire logic [`TCW_ADDR_W-1:0] paddr,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  output tcw_bus_req_t                req,
  output logic                        pready,
  output logic                        pslverr
);

  wire logic access;
  wire logic mapped;

  assign req.hit_ctrl   = (paddr == `TCW_CTRL_OFS);
  assign req.hit_cmp_lo = (paddr == `TCW_CMP_LO_OFS);
  assign req.hit_cmp_hi = (paddr == `TCW_CMP_HI_OFS);
  assign req.hit_count  = (paddr == `TCW_COUNT_OFS);
  assign req.setup      = psel & ~penable;
  assign access         = psel & penable;
  assign req.wr         = access & pwrite & mapped;
  assign mapped         = req.hit_ctrl | req.hit_cmp_lo | req.hit_cmp_hi | req.hit_count;
  // Zero wait states; unmapped words answer with an error and have no effect
  assign pready         = 1'b1;
  assign pslverr        = access & ~mapped;

endmodule // tcw_apb_decode

// ===== rtl/tcw_tick_gen.sv
// Prescaler chains that turn the two base clock ticks into divided tap ticks
`include "tcw_regs.svh"

module tcw_tick_gen
  import tcw_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic hf_tick,
  input  wire logic lf_tick,
  output tcw_taps_t taps
);

  logic [`TCW_HF_DIV_W-1:0] hf_div;
  logic [`TCW_LF_DIV_W-1:0] lf_div;
  tcw_taps_t                next_taps;

  // One tap tick per 2^n base ticks: the base tick that rolls the low n bits over
  function automatic logic tap_hit(input logic [31:0] ctr, input int n);
    logic [31:0] mask;
    mask    = (32'h1 << n) - 32'h1;
    tap_hit = ((ctr & mask) == mask);
  endfunction

  assign next_taps.hf   = hf_tick;
  assign next_taps.hf_a = hf_tick & tap_hit(32'(hf_div), `TCW_HF_TAP_A);
  assign next_taps.hf_b = hf_tick & tap_hit(32'(hf_div), `TCW_HF_TAP_B);
  assign next_taps.hf_c = hf_tick & tap_hit(32'(hf_div), `TCW_HF_TAP_C);
  assign next_taps.hf_d = hf_tick & tap_hit(32'(hf_div), `TCW_HF_TAP_D);
  assign next_taps.lf   = lf_tick;
  assign next_taps.lf_a = lf_tick & tap_hit(32'(lf_div), `TCW_LF_TAP_A);
  assign next_taps.lf_b = lf_tick & tap_hit(32'(lf_div), `TCW_LF_TAP_B);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hf_div <= '0;
      lf_div <= '0;
      taps   <= '0;
    end
    else
    begin
      hf_div <= hf_div + {{(`TCW_HF_DIV_W-1){1'b0}}, hf_tick};
      lf_div <= lf_div + {{(`TCW_LF_DIV_W-1){1'b0}}, lf_tick};
      taps   <= next_taps;
    end
  end

endmodule // tcw_tick_gen

// ===== rtl/tcw_timer.sv
// 16-bit timer, event counter and window counter with APB registers
//
// Local design decisions: the APB register port and the address map.
`include "tcw_regs.svh"

module tcw_timer
  import tcw_pkg::*;
(
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic [`TCW_ADDR_W-1:0] paddr,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [31:0]            pwdata,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   high_freq_clock,
  input  wire logic                   low_freq_clock,
  input  wire logic                   divider_tap_select,
  input  tcw_power_mode_t             power_mode,
  input  wire logic                   count_input_pin,
  output logic                        match_interrupt
);

  tcw_bus_req_t    req;
  tcw_taps_t       taps;
  tcw_ctrl_t       ctrl;
  tcw_ctrl_t       next_ctrl;
  tcw_op_t         op;
  logic [15:0]     compare;
  logic [15:0]     next_compare;
  logic [7:0]      low_pending;
  logic            low_written;
  logic            next_low_written;
  logic [15:0]     count;
  logic [15:0]     next_count;
  logic            next_match;
  logic [31:0]     next_prdata;
  logic            pin_meta;
  logic            pin_sync;
  logic            pin_prev;

  wire logic       slow_side;
  wire logic       in_stop;
  wire logic       fast_ok;
  wire logic       upper_only;
  wire logic       int_tick;
  wire logic       pin_rise;
  wire logic       pin_fall;
  wire logic       wr_ctrl;
  wire logic       wr_lo;
  wire logic       wr_hi;
  wire logic [7:0] ctrl_byte;
  wire logic [7:0] wbyte;
  wire logic       step_hit;
  wire logic       hold_hit;
  wire logic [15:0] count_inc;

  tcw_apb_decode u_decode
  (
    .paddr   (paddr),
    .psel    (psel),
    .penable (penable),
    .pwrite  (pwrite),
    .req     (req),
    .pready  (pready),
    .pslverr (pslverr)
  );

  tcw_tick_gen u_ticks
  (
    .pclk    (pclk),
    .presetn (presetn),
    .hf_tick (high_freq_clock),
    .lf_tick (low_freq_clock),
    .taps    (taps)
  );

  // Compare against the held value; the fast warm-up case looks at the top bits only
  function automatic logic cmp_match(input logic [15:0] cnt,
                                     input logic [15:0] cmp,
                                     input logic        upper);
    if (upper)
      cmp_match = (cnt[15:`TCW_UPPER_LSB] == cmp[15:`TCW_UPPER_LSB]);
    else
      cmp_match = (cnt == cmp);
  endfunction

  // Internal source per code, divider select and power mode; unlisted pairs give no tick
  function automatic logic pick_tick(input logic [2:0]      src,
                                     input logic            dv,
                                     input logic            slow,
                                     input logic            fast_allowed,
                                     input tcw_taps_t       t);
    case (src)
      `TCW_SRC_TAP0:    pick_tick = (slow | dv) ? t.lf_a : t.hf_a;
      `TCW_SRC_TAP1:    pick_tick = (slow | dv) ? t.lf_b : t.hf_b;
      `TCW_SRC_TAP2:    pick_tick = slow ? 1'b0 : t.hf_c;
      `TCW_SRC_TAP3:    pick_tick = slow ? 1'b0 : t.hf_d;
      `TCW_SRC_FAST:    pick_tick = fast_allowed & t.hf;
      `TCW_SRC_SLOWCLK: pick_tick = slow ? 1'b0 : t.lf;
      default:          pick_tick = 1'b0;
    endcase
  endfunction

  assign slow_side = (power_mode == TCW_PM_LOW_SPEED_MODE_ONE) | (power_mode == TCW_PM_LOW_SPEED_MODE_TWO) |
                     (power_mode == TCW_PM_SLEEP1) | (power_mode == TCW_PM_SLEEP2);
  assign in_stop   = (power_mode == TCW_PM_STOP);

  // Fast clock runs the count while the oscillator warms up on the way out of slow one
  assign fast_ok    = ~ctrl.mode_select &
                      ((power_mode == TCW_PM_LOW_SPEED_MODE_TWO) |
                       (power_mode == TCW_PM_LOW_SPEED_MODE_ONE));
  assign upper_only = fast_ok & (ctrl.source_clock_select == `TCW_SRC_FAST) &
                      (power_mode == TCW_PM_LOW_SPEED_MODE_TWO);
  assign int_tick   = pick_tick(ctrl.source_clock_select, divider_tap_select,
                                slow_side, fast_ok, taps);

  // Mode decode: pin source without window bit is the event counter
  assign op = ctrl.mode_select ? TCW_OP_WINDOW :
              (ctrl.source_clock_select == `TCW_SRC_PIN) ? TCW_OP_EVENT :
              TCW_OP_TIMER;

  assign pin_rise = pin_sync & ~pin_prev;
  assign pin_fall = ~pin_sync & pin_prev;

  assign wbyte     = pwdata[7:0];
  assign wr_ctrl   = req.wr & req.hit_ctrl;
  assign wr_lo     = req.wr & req.hit_cmp_lo;
  assign wr_hi     = req.wr & req.hit_cmp_hi;

  assign count_inc = count + 16'h0001;
  assign step_hit  = cmp_match(count_inc, compare, upper_only);
  assign hold_hit  = cmp_match(count, compare, 1'b0);

  // Undefined bits are read back as zero here
  assign ctrl_byte = {2'b00, ctrl.run_control, ctrl.source_clock_select[2:1],
                      ctrl.source_clock_select[0], 1'b0, ctrl.mode_select};

  // Control register; stop mode wins over a software start
  always_comb
  begin
    next_ctrl = ctrl;
    if (wr_ctrl)
    begin
      next_ctrl.run_control         = wbyte[`TCW_RUN_BIT];
      next_ctrl.source_clock_select = wbyte[`TCW_SRC_MSB:`TCW_SRC_LSB];
      next_ctrl.mode_select         = wbyte[`TCW_MODE_BIT];
    end
    if (in_stop)
      next_ctrl.run_control = 1'b0;
  end

  // Compare pair: low byte parks, high byte commits both halves together; in the fast slow-two case a lone high byte sets the top half alone
  always_comb
  begin
    next_compare     = compare;
    next_low_written = low_written;
    if (wr_lo)
      next_low_written = 1'b1;
    if (wr_hi)
    begin
      if (low_written)
      begin
        next_compare     = {wbyte, low_pending};
        next_low_written = 1'b0;
      end
      else if (upper_only)
        next_compare = {wbyte, compare[7:0]};
    end
  end

  // Counting per operation kind
  always_comb
  begin
    next_count = count;
    next_match = 1'b0;
    if (!ctrl.run_control)
      next_count = `TCW_COUNT_RST;
    else
    begin
      case (op)
        TCW_OP_TIMER:
        begin
          if (int_tick)
          begin
            if (step_hit)
            begin
              next_count = `TCW_COUNT_RST;
              next_match = 1'b1;
            end
            else
              next_count = count_inc;
          end
        end
        TCW_OP_EVENT:
        begin
          // Edges are at least one cycle apart, so rise and fall never coincide
          if (pin_rise)
            next_count = count_inc;
          else if (pin_fall && hold_hit)
          begin
            next_count = `TCW_COUNT_RST;
            next_match = 1'b1;
          end
        end
        TCW_OP_WINDOW:
        begin
          // Synchronised pin gates the tick; a window far slower than the tick is assumed
          if (int_tick && pin_sync)
          begin
            if (step_hit)
            begin
              next_count = `TCW_COUNT_RST;
              next_match = 1'b1;
            end
            else
              next_count = count_inc;
          end
        end
        default:
          next_count = count;
      endcase
    end
  end

  // Read data is latched in the setup cycle so it stands from a flop in the access cycle
  always_comb
  begin
    next_prdata = prdata;
    if (req.setup)
    begin
      next_prdata = 32'h0000_0000;
      if (req.hit_ctrl)
        next_prdata = {24'h00_0000, ctrl_byte};
      else if (req.hit_cmp_lo)
        next_prdata = {24'h00_0000, compare[7:0]};
      else if (req.hit_cmp_hi)
        next_prdata = {24'h00_0000, compare[15:8]};
      else if (req.hit_count)
        next_prdata = {16'h0000, count};
    end
  end

  // Pin synchroniser and edge history
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_meta <= 1'b0;
      pin_sync <= 1'b0;
      pin_prev <= 1'b0;
    end
    else
    begin
      pin_meta <= count_input_pin;
      pin_sync <= pin_meta;
      pin_prev <= pin_sync;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl        <= tcw_ctrl_t'(5'(`TCW_CTRL_RST));
      compare     <= `TCW_CMP_RST;
      low_pending <= 8'h00;
      low_written <= 1'b0;
    end
    else
    begin
      ctrl        <= next_ctrl;
      compare     <= next_compare;
      low_pending <= wr_lo ? wbyte : low_pending;
      low_written <= next_low_written;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count           <= `TCW_COUNT_RST;
      match_interrupt <= 1'b0;
      prdata          <= 32'h0000_0000;
    end
    else
    begin
      count           <= next_count;
      match_interrupt <= next_match;
      prdata          <= next_prdata;
    end
  end

endmodule // tcw_timer

// ===== testbench/tcw_timer_properties.sv
// Port-level checker for the window timer
`include "tcw_regs.svh"

module tcw_timer_checker
  import tcw_pkg::*;
(
  input wire logic                   pclk,
  input wire logic                   presetn,
  input wire logic [`TCW_ADDR_W-1:0] paddr,
  input wire logic                   psel,
  input wire logic                   penable,
  input wire logic                   pwrite,
  input wire logic [31:0]            pwdata,
  input wire logic [31:0]            prdata,
  input wire logic                   pready,
  input wire logic                   pslverr,
  input wire logic                   high_freq_clock,
  input wire logic                   low_freq_clock,
  input wire logic                   divider_tap_select,
  input tcw_power_mode_t             power_mode,
  input wire logic                   count_input_pin,
  input wire logic                   match_interrupt
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       run_sh;
  logic       win_sh;
  logic [2:0] src_sh;
  wire logic  acc = psel && penable;
  wire logic  ctl_wr = acc && pwrite && (paddr == `TCW_CTRL_OFS);
  wire logic  win_on = run_sh && win_sh;
  wire logic  evt_on = run_sh && !win_sh && (src_sh == `TCW_SRC_PIN);
  // Shadow of the control fields; stop mode beats a same-cycle write
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      {run_sh, src_sh, win_sh} <= '0;
    else if (power_mode == TCW_PM_STOP)
      run_sh <= 1'b0;
    else if (ctl_wr)
      {run_sh, src_sh, win_sh} <= {pwdata[5], pwdata[4:2], pwdata[0]};
  sequence s_ctl_rd; acc && !pwrite && (paddr == `TCW_CTRL_OFS); endsequence
  sequence s_win_low; (win_on && !count_input_pin)[*8]; endsequence
  sequence s_evt_high; (evt_on && count_input_pin)[*8]; endsequence
  property p_ready; acc |-> pready; endproperty
  property p_err_map; acc |-> pslverr == !(paddr inside {12'h000, 12'h004, 12'h008, 12'h00C});
  endproperty
  property p_ctl_rsvd; s_ctl_rd |-> prdata[7:6] == 2'b00 && !prdata[1]; endproperty
  property p_irq_pulse; match_interrupt |=> !match_interrupt; endproperty
  property p_stop_quiet; (power_mode == TCW_PM_STOP)[*3] |-> !match_interrupt; endproperty
  property p_idle; (!run_sh)[*4] |-> !match_interrupt; endproperty
  property p_rsvd_src; (run_sh && src_sh == `TCW_SRC_RSVD)[*4] |-> !match_interrupt;
  endproperty
  property p_win_low; s_win_low |-> !match_interrupt; endproperty
  property p_evt_high; s_evt_high |-> !match_interrupt; endproperty
  a_ready: assert property (p_ready) else $error("pready low in access");
  a_err_map: assert property (p_err_map) else $error("pslverr wrong");
  a_ctl_rsvd: assert property (p_ctl_rsvd) else $error("control spare bits set");
  a_irq_pulse: assert property (p_irq_pulse) else $error("interrupt too long");
  a_stop_quiet: assert property (p_stop_quiet) else $error("interrupt in stop");
  a_idle: assert property (p_idle) else $error("interrupt while stopped");
  a_rsvd_src: assert property (p_rsvd_src) else $error("reserved source ticks");
  a_win_low: assert property (p_win_low) else $error("window counts pin low");
  a_evt_high: assert property (p_evt_high) else $error("event match not on fall");
endmodule // tcw_timer_checker

bind tcw_timer tcw_timer_checker u_chk (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .high_freq_clock(high_freq_clock), .low_freq_clock(low_freq_clock),
  .divider_tap_select(divider_tap_select), .power_mode(power_mode),
  .count_input_pin(count_input_pin), .match_interrupt(match_interrupt));

// ===== testbench/tcw_pin_src.sv
// External event and window pulse source model
module tcw_pin_src
(
  input  wire logic pclk,
  output logic      pin
);
  timeunit 1ns;
  timeprecision 100ps;
  initial pin = 1'b0;
  // Callers keep both levels at eight cycles or more
  task automatic pulses(input int n, input int hi, input int lo);
    repeat (n)
    begin
      @(posedge pclk);
      pin <= 1'b1;
      repeat (hi) @(posedge pclk);
      pin <= 1'b0;
      repeat (lo - 1) @(posedge pclk);
    end
  endtask
  // Window edges come seldom next to the count tick
  task automatic level(input logic v);
    @(posedge pclk);
    pin <= v;
  endtask
endmodule // tcw_pin_src

// ===== testbench/tb_top.sv
// Self-checking bench for the window timer
`include "tcw_regs.svh"

module tb_top
  import tcw_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 100ps;
  logic                   pclk = 1'b0;
  logic                   presetn = 1'b0;
  logic [`TCW_ADDR_W-1:0] paddr = '0;
  logic                   psel = 1'b0;
  logic                   penable = 1'b0;
  logic                   pwrite = 1'b0;
  logic [31:0]            pwdata = '0;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic                   lf_clk = 1'b0;
  logic [1:0]             lf_div = '0;
  tcw_power_mode_t        power_mode = TCW_PM_NORMAL_MODE_TWO;
  logic                   pin;
  logic                   irq;
  logic [33:0]            e_bus;
  logic [33:0]            exp_bus[$];
  int                     exp_gap[$];
  int                     n_errors = 0;
  int                     check_count = 0;
  int                     cyc = 0;
  int                     last_irq = 0;
  int                     irq_cnt = 0;
  int                     g;
  logic                   hf_clk = 1'b1;
  logic                   dv_sel = 1'b0;
  logic [2:0]             srcs[4] = '{3'h3, 3'h2, 3'h5, 3'h1};
  int                     divs[4] = '{8, 256, 4, 128};

  initial
  begin
    forever #2.5 pclk = ~pclk;
  end

  tcw_timer DUT (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .high_freq_clock(hf_clk), .low_freq_clock(lf_clk), .divider_tap_select(dv_sel),
    .power_mode(power_mode), .count_input_pin(pin), .match_interrupt(irq));
  tcw_pin_src u_src (.pclk(pclk), .pin(pin));

  task automatic conclude();
    if (n_errors == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] s);
    check_count++;
    if (s !== e)
    begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, e, s);
    end
  endtask

  // Slow clock as one pulse every fourth cycle
  always @(posedge pclk)
  begin
    lf_div <= lf_div + 2'h1;
    lf_clk <= (lf_div == 2'h3);
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      n_errors++;
      conclude();
    end
  end

  // Sampled mid-cycle so flop updates have settled
  always @(negedge pclk)
  begin
    if (psel && penable && pready === 1'b1 && exp_bus.size() > 0)
    begin
      e_bus = exp_bus.pop_front();
      chk("pslverr", {31'h0, e_bus[32]}, {31'h0, pslverr});
      if (e_bus[33])
        chk("prdata", e_bus[31:0], prdata);
    end
    if (irq === 1'b1)
    begin
      irq_cnt++;
      if (exp_gap.size() > 0)
      begin
        g = exp_gap.pop_front();
        if (g >= 0)
          chk("interrupt gap", g, cyc - last_irq);
      end
      last_irq = cyc;
    end
  end

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [31:0] e, input logic err);
    exp_bus.push_back({~w, err, e});
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // The guard reads pready as it stood when the edge came
    @(posedge pclk iff (pready === 1'b1));
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, '0, 1'b0);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic err);
    apb(1'b0, a, '0, e, err);
  endtask

  function automatic logic [31:0] ctl(input logic r, input logic [2:0] s, input logic m);
    return {26'h0, r, s, 1'b0, m};
  endfunction

  task automatic set_cmp(input logic [15:0] c);
    wr(`TCW_CMP_LO_OFS, {24'h0, c[7:0]});
    wr(`TCW_CMP_HI_OFS, {24'h0, c[15:8]});
  endtask

  task automatic wait_irq(input int n);
    int t;
    t = irq_cnt + n;
    wait (irq_cnt >= t);
  endtask

  initial
  begin
    logic [7:0] rv;
    logic [7:0] lo;
    int         base;
    void'($urandom(32'hAB26));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rv = 8'($urandom());
    wr(`TCW_CTRL_OFS, {24'h0, rv & 8'hDF});
    rd(`TCW_CTRL_OFS, {24'h0, rv & 8'h1D}, 1'b0);
    wr(`TCW_COUNT_OFS, 32'h0000_00FF);
    rd(`TCW_COUNT_OFS, 32'h0, 1'b0);
    rd(12'h010, 32'h0, 1'b1);
    base = irq_cnt;
    wr(`TCW_CTRL_OFS, ctl(1'b1, `TCW_SRC_RSVD, 1'b0));
    // Random fast ticks must still give no interrupt on the reserved code
    repeat (60)
    begin
      hf_clk <= 1'($urandom());
      @(posedge pclk);
    end
    hf_clk <= 1'b1;
    chk("reserved source interrupts", base, irq_cnt);
    wr(`TCW_CTRL_OFS, ctl(1'b0, `TCW_SRC_RSVD, 1'b0));
    set_cmp(16'h0003);
    for (int i = 0; i < 4; i++)
    begin
      // Last pass takes the slow-clock tap through the divider select
      dv_sel <= (i == 3) ? 1'b1 : 1'($urandom_range(1));
      exp_gap.push_back(-1);
      exp_gap.push_back(3 * divs[i]);
      exp_gap.push_back(3 * divs[i]);
      wr(`TCW_CTRL_OFS, ctl(1'b1, srcs[i], 1'b0));
      wait_irq(3);
      wr(`TCW_CTRL_OFS, ctl(1'b0, srcs[i], 1'b0));
    end
    // Lone low byte must leave the old compare in force
    lo = 8'(4 + $urandom_range(3));
    exp_gap.push_back(-1);
    exp_gap.push_back(24);
    exp_gap.push_back(24);
    wr(`TCW_CTRL_OFS, ctl(1'b1, 3'h3, 1'b0));
    wr(`TCW_CMP_LO_OFS, {24'h0, lo});
    wait_irq(3);
    exp_gap.push_back(-1);
    exp_gap.push_back(8 * lo);
    wr(`TCW_CMP_HI_OFS, 32'h0);
    wait_irq(2);
    wr(`TCW_CTRL_OFS, ctl(1'b0, 3'h3, 1'b0));
    // Fast clock in slow two: a lone high byte sets the top bits, period 2 << 11 ticks
    power_mode <= TCW_PM_LOW_SPEED_MODE_TWO;
    wr(`TCW_CTRL_OFS, ctl(1'b0, `TCW_SRC_FAST, 1'b0));
    wr(`TCW_CMP_HI_OFS, 32'h0000_0010);
    rd(`TCW_CMP_HI_OFS, 32'h0000_0010, 1'b0);
    exp_gap.push_back(-1);
    exp_gap.push_back(4096);
    wr(`TCW_CTRL_OFS, ctl(1'b1, `TCW_SRC_FAST, 1'b0));
    wait_irq(2);
    wr(`TCW_CTRL_OFS, ctl(1'b0, `TCW_SRC_FAST, 1'b0));
    power_mode <= TCW_PM_NORMAL_MODE_TWO;
    set_cmp(16'h0003);
    exp_gap.push_back(-1);
    exp_gap.push_back(72);
    base = irq_cnt;
    wr(`TCW_CTRL_OFS, ctl(1'b1, `TCW_SRC_PIN, 1'b0));
    u_src.pulses(7, 12, 12);
    repeat (20) @(posedge pclk);
    chk("event interrupts", base + 2, irq_cnt);
    wr(`TCW_CTRL_OFS, ctl(1'b0, `TCW_SRC_PIN, 1'b0));
    base = irq_cnt;
    wr(`TCW_CTRL_OFS, ctl(1'b1, 3'h3, 1'b1));
    repeat (100) @(posedge pclk);
    chk("window idle interrupts", base, irq_cnt);
    exp_gap.push_back(-1);
    exp_gap.push_back(24);
    u_src.level(1'b1);
    wait_irq(2);
    u_src.level(1'b0);
    power_mode <= TCW_PM_STOP;
    repeat (4) @(posedge pclk);
    power_mode <= TCW_PM_NORMAL_MODE_TWO;
    rd(`TCW_CTRL_OFS, ctl(1'b0, 3'h3, 1'b1), 1'b0);
    repeat (4) @(posedge pclk);
    chk("pending gaps", 0, exp_gap.size());
    conclude();
  end
endmodule // tb_top
